// ==== design/sync_out_params.sv ====
// output synchronisation parameter entries with timing measurement
// Functional notes
// - modes 0 free, 1 sm event, 2 sync0
// - mode 3 syncs outputs to sync1
// - 32-bit cycle time, reset 0x000f4240
// - read-only shift time sync0 to output
// - supported modes word reads 0x4807
// - minimum cycle time resets to 0x000103c4
// - read-only minimum sync0 to sync1 gap
// - command 1 starts, 0 stops measurement
// - keep maxima, clear before next measurement
// - read-only delay sync1 to output
// - count missed sm events in dc op
// - count overruns and early cycles in op
// - count too-short sync0 to sync1 gaps
// - late output flag, dc mode only
`timescale 1ns/1ps
`include "sync_out_regs.svh"
module sync_out_params
  import sync_out_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  // object dictionary access, subindex selects the entry
  input wire logic [7:0] sub_index,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] wr_data,
  output logic [31:0] rd_data,
  output logic rd_valid,
  output logic rd_error,
  // device state and sync events
  input wire logic operational,
  input wire logic sm_event,
  input wire logic sync0_event,
  input wire logic sync1_event,
  input wire logic cycle_done,
  input wire logic outputs_driven,
  // mode and period for the output logic
  output sync_mode_t sync_mode,
  output logic [31:0] cycle_time,
  output logic late_output_flag
);
  typedef struct packed
  {
    sync_mode_t mode;
    logic [31:0] cycle_time;
    logic [15:0] measure_command;
    meas_state_t meas;
    logic [31:0] shift_time;
    logic [31:0] calc_copy_time;
    logic [31:0] minimum_delay_time;
    logic [31:0] output_delay_time;
    logic [31:0] minimum_cycle_time;
    logic [31:0] since_sync0; // ns since last sync0
    logic [31:0] since_sync1; // ns since last sync1
    logic [31:0] since_cycle; // ns since cycle start
    logic cycle_open; // cycle started, not done
    logic sm_seen; // sm event since last sync0
    logic driven_seen; // outputs driven this cycle
    logic late;
    logic [31:0] rd_data;
    logic rd_valid;
    logic rd_error;
  } top_state_t;
  top_state_t state;
  top_state_t next_state;
  err_cnt_if missed_if();
  err_cnt_if overrun_if();
  err_cnt_if short_if();
  logic dc_mode;
  logic cycle_start;
  assign dc_mode = (state.mode == MODE_DC_SYNC0) || (state.mode == MODE_DC_SYNC1);
  // cycle start source follows the mode
  // sync1 paces outputs in mode 3
  always_comb
  begin
    case (state.mode)
      MODE_FREE_RUN: cycle_start = state.since_cycle >= state.cycle_time;
      MODE_SM_EVENT: cycle_start = sm_event;
      MODE_DC_SYNC0: cycle_start = sync0_event;
      MODE_DC_SYNC1: cycle_start = sync1_event;
      default: cycle_start = 1'b0;
    endcase
  end
  // sync0 with no sm event since the last one
  assign missed_if.bump = dc_mode && operational && sync0_event && !state.sm_seen;
  assign overrun_if.bump = operational && state.cycle_open &&
    (cycle_start || state.since_cycle > state.cycle_time);
  // sync1 sooner than the calc-and-copy minimum
  assign short_if.bump = dc_mode && sync1_event &&
    (state.since_sync0 < state.calc_copy_time);
  // saturating error counters
  sat_counter u_missed (.clk(clk), .reset_n(reset_n), .port_c(missed_if.counter));
  sat_counter u_overrun (.clk(clk), .reset_n(reset_n), .port_c(overrun_if.counter));
  sat_counter u_short (.clk(clk), .reset_n(reset_n), .port_c(short_if.counter));
  // next-state logic: register access, measurement, cycle tracking
  always_comb
  begin
    next_state = state;
    next_state.rd_valid = 1'b0;
    next_state.rd_error = 1'b0;
    // elapsed time counters, stop one step short of the top so they never alias
    // steps are whole clocks, so an equality test against all ones would never hit
    if (state.since_sync0 <= (32'hffffffff - `NS_PER_CLK))
    begin
      next_state.since_sync0 = state.since_sync0 + `NS_PER_CLK;
    end
    if (state.since_sync1 <= (32'hffffffff - `NS_PER_CLK))
    begin
      next_state.since_sync1 = state.since_sync1 + `NS_PER_CLK;
    end
    if (state.since_cycle <= (32'hffffffff - `NS_PER_CLK))
    begin
      next_state.since_cycle = state.since_cycle + `NS_PER_CLK;
    end
    // events load one clock, so the value seen at a later edge is the true gap
    if (sync0_event)
    begin
      next_state.since_sync0 = `NS_PER_CLK;
      next_state.sm_seen = 1'b0;
    end
    if (sync1_event)
    begin
      next_state.since_sync1 = `NS_PER_CLK;
    end
    if (sm_event)
    begin
      next_state.sm_seen = 1'b1;
    end
    if (cycle_done)
    begin
      next_state.cycle_open = 1'b0;
    end
    // an overrun closes the cycle, so it counts once and not every clock
    if (overrun_if.bump)
    begin
      next_state.cycle_open = 1'b0;
    end
    if (outputs_driven)
    begin
      next_state.driven_seen = 1'b1;
    end
    // cycle boundary: judge the finished cycle, open a new one
    if (cycle_start)
    begin
      next_state.since_cycle = `NS_PER_CLK;
      next_state.cycle_open = 1'b1;
      next_state.driven_seen = 1'b0;
      // late if outputs not driven in time
      next_state.late = dc_mode && !(state.driven_seen || outputs_driven);
    end
    if (!dc_mode)
    begin
      next_state.late = 1'b0;
    end
    if (state.meas == ST_TIMING)
    begin
      if (outputs_driven && dc_mode && state.since_sync0 > state.shift_time)
      begin
        next_state.shift_time = state.since_sync0;
      end
      if (outputs_driven && dc_mode && state.since_sync1 > state.output_delay_time)
      begin
        next_state.output_delay_time = state.since_sync1;
      end
      if (sync1_event && dc_mode && state.since_sync0 > state.calc_copy_time)
      begin
        next_state.calc_copy_time = state.since_sync0;
      end
      if (cycle_done && state.since_cycle > state.minimum_cycle_time)
      begin
        next_state.minimum_cycle_time = state.since_cycle;
      end
      if (outputs_driven && state.since_cycle > state.minimum_delay_time)
      begin
        next_state.minimum_delay_time = state.since_cycle;
      end
    end
    // measurement sequencing
    case (state.meas)
      ST_IDLE: next_state.meas = ST_IDLE;
      ST_WAIT:
      begin
        next_state.shift_time = 32'h0;
        next_state.calc_copy_time = 32'h0;
        next_state.minimum_delay_time = 32'h0;
        next_state.output_delay_time = 32'h0;
        next_state.minimum_cycle_time = 32'h0;
        next_state.meas = ST_TIMING;
      end
      ST_TIMING: next_state.meas = ST_TIMING;
      default: next_state.meas = ST_IDLE;
    endcase
    // entry writes; read-only entries ignore the write
    if (wr_en)
    begin
      case (sub_index)
        `SUB_SYNC_MODE: next_state.mode = sync_mode_t'(wr_data[1:0]);
        `SUB_CYCLE_TIME: next_state.cycle_time = wr_data;
        `SUB_COMMAND:
        begin
          next_state.measure_command = wr_data[15:0];
          if (wr_data[15:0] == `CMD_START)
          begin
            next_state.meas = ST_WAIT;
          end
          else if (wr_data[15:0] == `CMD_STOP)
          begin
            next_state.meas = ST_IDLE;
          end
        end
        default: next_state.rd_error = 1'b0;
      endcase
    end
    // entry reads, answered one cycle later
    if (rd_en)
    begin
      next_state.rd_valid = 1'b1;
      case (sub_index)
        `SUB_SYNC_MODE: next_state.rd_data = {30'h0, state.mode};
        `SUB_CYCLE_TIME: next_state.rd_data = state.cycle_time;
        `SUB_SHIFT_TIME: next_state.rd_data = state.shift_time;
        `SUB_SUPPORTED: next_state.rd_data = {16'h0, `RST_SUPPORTED};
        `SUB_MIN_CYCLE: next_state.rd_data = state.minimum_cycle_time;
        `SUB_CALC_COPY: next_state.rd_data = state.calc_copy_time;
        `SUB_MIN_DELAY: next_state.rd_data = state.minimum_delay_time;
        `SUB_COMMAND: next_state.rd_data = {16'h0, state.measure_command};
        `SUB_DELAY_TIME: next_state.rd_data = state.output_delay_time;
        `SUB_MISSED: next_state.rd_data = {16'h0, missed_if.count};
        `SUB_OVERRUN: next_state.rd_data = {16'h0, overrun_if.count};
        `SUB_SHORT_SHIFT: next_state.rd_data = {16'h0, short_if.count};
        `SUB_LATE_FLAG: next_state.rd_data = {31'h0, state.late};
        default:
        begin
          next_state.rd_data = 32'h0;
          next_state.rd_error = 1'b1;
        end
      endcase
    end
  end
  // single state register
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state <= '0;
      state.mode <= sync_mode_t'(2'(`RST_SYNC_MODE));
      state.cycle_time <= `RST_CYCLE_TIME;
      state.minimum_cycle_time <= `RST_MIN_CYCLE;
    end
    else
    begin
      state <= next_state;
    end
  end
  assign rd_data = state.rd_data;
  assign rd_valid = state.rd_valid;
  assign rd_error = state.rd_error;
  assign sync_mode = state.mode;
  assign cycle_time = state.cycle_time;
  assign late_output_flag = state.late;
  // start write enters wait next cycle, shift maximum cleared the cycle after
  a_start_clears: assert property (@(posedge clk) disable iff (!reset_n)
    wr_en && sub_index == `SUB_COMMAND && wr_data[15:0] == `CMD_START
    |=> state.meas == ST_WAIT ##1 state.shift_time == 32'h0)
    else $error("start did not clear maxima");
  // flag stays low outside dc modes
  a_late_dc_only: assert property (@(posedge clk) disable iff (!reset_n)
    !$past(dc_mode) |-> !late_output_flag)
    else $error("late flag outside dc mode");
  a_supported_word: assert property (@(posedge clk) disable iff (!reset_n)
    rd_en && sub_index == `SUB_SUPPORTED |=> rd_valid && rd_data == 32'h00004807)
    else $error("supported modes wrong");
  a_missed_count: assert property (@(posedge clk) disable iff (!reset_n)
    missed_if.bump && missed_if.count != 16'hffff
    |=> missed_if.count == $past(missed_if.count) + 16'h0001)
    else $error("missed count not bumped");
  a_overrun_count: assert property (@(posedge clk) disable iff (!reset_n)
    overrun_if.bump && overrun_if.count != 16'hffff
    |=> overrun_if.count == $past(overrun_if.count) + 16'h0001)
    else $error("overrun count not bumped");
  a_short_count: assert property (@(posedge clk) disable iff (!reset_n)
    short_if.bump && short_if.count != 16'hffff
    |=> short_if.count == $past(short_if.count) + 16'h0001)
    else $error("short count not bumped");
  a_cycle_write: assert property (@(posedge clk) disable iff (!reset_n)
    wr_en && sub_index == `SUB_CYCLE_TIME |=> cycle_time == $past(wr_data))
    else $error("cycle time not written");
  a_max_hold: assert property (@(posedge clk) disable iff (!reset_n)
    state.meas == ST_TIMING && $past(state.meas) == ST_TIMING
    |-> state.shift_time >= $past(state.shift_time))
    else $error("shift maximum shrank");
endmodule

// ==== inc/sync_out_regs.svh ====
// register offsets, reset values and command codes for the output sync block
`ifndef SYNC_OUT_REGS_SVH
`define SYNC_OUT_REGS_SVH
`define SUB_SYNC_MODE 8'h01
`define SUB_CYCLE_TIME 8'h02
`define SUB_SHIFT_TIME 8'h03
`define SUB_SUPPORTED 8'h04
`define SUB_MIN_CYCLE 8'h05
`define SUB_CALC_COPY 8'h06
`define SUB_MIN_DELAY 8'h07
`define SUB_COMMAND 8'h08
`define SUB_DELAY_TIME 8'h09
`define SUB_MISSED 8'h0b
`define SUB_OVERRUN 8'h0c
`define SUB_SHORT_SHIFT 8'h0d
`define SUB_LATE_FLAG 8'h20
`define RST_SYNC_MODE 16'h0001
`define RST_CYCLE_TIME 32'h000f4240
`define RST_SUPPORTED 16'h4807
`define RST_MIN_CYCLE 32'h000103c4
`define CMD_START 16'h0001
`define CMD_STOP 16'h0000
`define NS_PER_CLK 32'h0000000a
`endif

// ==== inc/sync_out_pkg.sv ====
// types for the output sync parameter block
package sync_out_pkg;
  typedef enum logic [1:0]
  {
    MODE_FREE_RUN = 2'b00,
    MODE_SM_EVENT = 2'b01,
    MODE_DC_SYNC0 = 2'b10,
    MODE_DC_SYNC1 = 2'b11
  } sync_mode_t;
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_TIMING = 2'b10
  } meas_state_t;
endpackage

// ==== inc/err_cnt_if.sv ====
// carrier between top and saturating error counters
`timescale 1ns/1ps
interface err_cnt_if;
  logic bump;
  logic [15:0] count;
  modport owner (output bump, input count);
  modport counter (input bump, output count);
endinterface

// ==== design/sat_counter.sv ====
// 16-bit saturating event counter
`timescale 1ns/1ps
module sat_counter
  import sync_out_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  err_cnt_if.counter port_c
);
  typedef struct packed
  {
    logic [15:0] count;
  } cnt_state_t;
  cnt_state_t state;
  cnt_state_t next_state;
  // step unless already pinned at the top
  always_comb
  begin
    next_state = state;
    if (port_c.bump && state.count != 16'hffff)
    begin
      next_state.count = state.count + 16'h0001;
    end
  end
  // registered count, cleared by reset
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end
  assign port_c.count = state.count;
  a_count_saturates: assert property (@(posedge clk) disable iff (!reset_n)
    $past(state.count) == 16'hffff |-> state.count == 16'hffff)
    else $error("counter wrapped");
endmodule

// ==== tb/sync_master_model.sv ====
// fieldbus master model producing the sync events of one bus cycle
`timescale 1ns/1ps
module sync_master_model
(
  input wire logic clk,
  output logic sm_event,
  output logic sync0_event,
  output logic sync1_event,
  output logic cycle_done,
  output logic outputs_driven
);
  // all event lines idle low until a cycle is requested
  initial
  begin
    sm_event = 1'b0;
    sync0_event = 1'b0;
    sync1_event = 1'b0;
    cycle_done = 1'b0;
    outputs_driven = 1'b0;
  end

  // sm event one clock ahead of sync0, so it belongs to this cycle
  // gap sets sync0 to sync1 spacing; drv and done may be withheld
  task automatic run_cycle(input bit sm, input int gap, input bit drv, input bit done);
    @(posedge clk) sm_event <= sm;
    @(posedge clk)
    begin
      sm_event <= 1'b0;
      sync0_event <= 1'b1;
    end
    @(posedge clk) sync0_event <= 1'b0;
    repeat (gap) @(posedge clk);
    sync1_event <= 1'b1;
    @(posedge clk)
    begin
      sync1_event <= 1'b0;
      outputs_driven <= drv;
    end
    @(posedge clk)
    begin
      outputs_driven <= 1'b0;
      cycle_done <= done;
    end
    @(posedge clk) cycle_done <= 1'b0;
  endtask
endmodule

// ==== tb/test_sync_out_params.sv ====
// self-checking bench for the output sync parameter block
`timescale 1ns/1ps
`include "sync_out_regs.svh"
module test_sync_out_params
  import sync_out_pkg::*;
;
  logic clk;
  logic reset_n;
  logic [7:0] sub_index;
  logic wr_en;
  logic rd_en;
  logic [31:0] wr_data;
  logic [31:0] rd_data;
  logic rd_valid;
  logic rd_error;
  logic operational;
  logic sm_event, sync0_event, sync1_event, cycle_done, outputs_driven;
  sync_mode_t sync_mode;
  logic [31:0] cycle_time;
  logic late_output_flag;
  int failures = 0;
  int comparisons = 0;
  logic [31:0] rv; // last read value
  logic re; // last read error
  logic [31:0] b0, b1, b2; // counter baselines

  sync_out_params sync_out_params_i (.clk(clk), .reset_n(reset_n), .sub_index(sub_index),
    .wr_en(wr_en), .rd_en(rd_en), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
    .rd_error(rd_error), .operational(operational), .sm_event(sm_event),
    .sync0_event(sync0_event), .sync1_event(sync1_event), .cycle_done(cycle_done),
    .outputs_driven(outputs_driven), .sync_mode(sync_mode), .cycle_time(cycle_time),
    .late_output_flag(late_output_flag));

  sync_master_model sync_master_model_i (.clk(clk), .sm_event(sm_event),
    .sync0_event(sync0_event), .sync1_event(sync1_event), .cycle_done(cycle_done),
    .outputs_driven(outputs_driven));

  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // read strobe, answer sampled once the following edge has landed
  task automatic rd(input logic [7:0] s);
    @(posedge clk);
    sub_index <= s;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    rv = rd_data;
    re = rd_error;
    check("rd_valid", {31'h0, rd_valid}, 32'h1);
  endtask

  task automatic wr(input logic [7:0] s, input logic [31:0] d);
    @(posedge clk);
    sub_index <= s;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // reset values of every entry but the mode, and of the mode and cycle time outputs
  task automatic t_reset();
    logic [7:0] subs [12] = '{8'h04, 8'h02, 8'h05, 8'h03, 8'h06, 8'h07, 8'h08, 8'h09,
      8'h0b, 8'h0c, 8'h0d, 8'h20};
    logic [31:0] exps [12] = '{32'h4807, 32'h000f4240, 32'h000103c4, 32'h0, 32'h0, 32'h0,
      32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    check("sync_mode", {30'h0, sync_mode}, 32'h1);
    check("cycle_time", cycle_time, 32'h000f4240);
    for (int i = 0; i < 12; i++)
    begin
      rd(subs[i]);
      check("reset_entry", rv, exps[i]);
    end
  endtask

  // read/write, read-only and unmapped entries
  task automatic t_access();
    wr(8'h02, 32'h00000190);
    rd(8'h02);
    check("cycle_rd", rv, 32'h00000190);
    check("cycle_port", cycle_time, 32'h00000190);
    wr(8'h04, 32'h0);
    rd(8'h04);
    check("supported_ro", rv, 32'h4807);
    wr(8'h05, 32'h5);
    rd(8'h05);
    check("min_cycle_ro", rv, 32'h000103c4);
    wr(8'h03, 32'h7);
    rd(8'h03);
    check("shift_ro", rv, 32'h0);
    rd(8'h0a);
    check("unmapped_err", {31'h0, re}, 32'h1);
    check("unmapped_data", rv, 32'h0);
  endtask

  // every mode code reaches the mode output
  task automatic t_modes();
    for (int m = 0; m < 4; m++)
    begin
      wr(8'h01, m);
      rd(8'h01);
      check("mode_rd", rv, m);
      check("mode_port", {30'h0, sync_mode}, m);
      if (m < 2)
        check("flag_non_dc", {31'h0, late_output_flag}, 32'h0);
    end
  endtask

  // start clears timings, a cycle loads them, stop freezes them
  task automatic t_measure();
    wr(8'h01, 32'h2);
    operational <= 1'b1;
    wr(8'h08, 32'h1);
    rd(8'h03);
    check("shift_clear", rv, 32'h0);
    rd(8'h05);
    check("min_cycle_clear", rv, 32'h0);
    sync_master_model_i.run_cycle(1'b1, 5, 1'b1, 1'b1);
    wr(8'h08, 32'h0);
    rd(8'h08);
    check("cmd_rd", rv, 32'h0);
    // model spacing: sync1 six clocks after sync0, outputs one later, done one later
    rd(8'h06);
    check("calc_loaded", rv, 32'h0000003c);
    rd(8'h09);
    check("delay_loaded", rv, 32'h0000000a);
    rd(8'h05);
    check("min_cycle_loaded", rv, 32'h00000050);
    rd(8'h07);
    check("min_delay_loaded", rv, 32'h00000046);
    rd(8'h03);
    b0 = rv;
    check("shift_loaded", rv, 32'h00000046);
    sync_master_model_i.run_cycle(1'b1, 9, 1'b1, 1'b1);
    rd(8'h03);
    check("shift_frozen", rv, b0);
  endtask

  // missed event, overrun, late flag and short shift in dc operation
  task automatic t_errors();
    sync_master_model_i.run_cycle(1'b1, 5, 1'b1, 1'b1);
    rd(8'h0b);
    b0 = rv;
    rd(8'h0c);
    b1 = rv;
    sync_master_model_i.run_cycle(1'b0, 5, 1'b0, 1'b0);
    sync_master_model_i.run_cycle(1'b1, 5, 1'b1, 1'b1);
    check("flag_port", {31'h0, late_output_flag}, 32'h1);
    rd(8'h20);
    check("flag_rd", rv, 32'h1);
    rd(8'h0b);
    check("missed", rv, b0 + 1);
    rd(8'h0c);
    check("overrun", rv, b1 + 1);
    rd(8'h0d);
    b2 = rv;
    sync_master_model_i.run_cycle(1'b1, 0, 1'b1, 1'b1);
    check("flag_clear", {31'h0, late_output_flag}, 32'h0);
    rd(8'h0d);
    check("short", rv, b2 + 1);
    // a cycle left open past the cycle time counts exactly once
    rd(8'h0c);
    b1 = rv;
    sync_master_model_i.run_cycle(1'b1, 5, 1'b1, 1'b0);
    repeat (40) @(posedge clk);
    rd(8'h0c);
    check("overrun_late", rv, b1 + 1);
  endtask

  task automatic print_verdict();
    if (failures == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // hang guard
  initial
  begin
    #1ms;
    failures++;
    print_verdict();
  end

  // main sequence after a two cycle reset
  initial
  begin
    reset_n = 1'b0;
    sub_index = 8'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    wr_data = 32'h0;
    operational = 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    t_reset();
    t_access();
    t_modes();
    t_measure();
    t_errors();
    print_verdict();
  end
endmodule
